// ---- common/snt_pkg.sv ----
//Contract
//[RULE1] All synchronous inputs are captured at the rising edge
//[RULE2] Burst order pin stays fixed during operation
//[RULE3] Sleep and output enable act asynchronously
//[RULE4] Output enable off forces drivers off at once
//[RULE5] Writes start at an edge, self timed
//[RULE6] Pipelined read data held, released next edge
//[RULE7] Reads and writes mix back to back freely
//[RULE8] Pipelined 3-1-1-1 or flow-through 2-1-1-1 reads
//[RULE9] Each 9-bit lane writes under its own enable
//[RULE10] Selected only when all three selects active
//[RULE11] Linear or interleaved burst order by pin
//[RULE12] Sleep request enters power-down automatically
//[RULE13] Boundary-scan test port per 1149.1
//[RULE14] Selects one and three low, two high
//[RULE15] Write strobe writes lanes whose enable is low
//[RULE16] Burst step high advances the burst counter
//[RULE17] Read path pin low flow-through, high pipelined
//[RULE18] Two address bits step four beats, wrap or XOR
//[RULE19] Write data taken two or one clocks later
package snt_pkg;
   // ***********************************************
   // Array shape
   // ***********************************************
   localparam int unsigned LANE_W  = 9;
   localparam int unsigned LANES   = 4;
   localparam int unsigned ADDR_W  = 10;
   localparam int unsigned BURST_W = 2;
   localparam int unsigned WORD_W  = LANE_W * LANES;
   // ***********************************************
   // Scan port
   // ***********************************************
   localparam int unsigned IR_W    = 3;
   localparam int unsigned ID_W    = 32;
   localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
   localparam logic [IR_W-1:0] IR_CAPT   = 3'h1;
   // Arbitrary neutral identity value
   localparam logic [ID_W-1:0] ID_VALUE  = 32'h0000_1001;
   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001, TAP_IDLE  = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
      TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
      TAP_UP_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
      TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UP_IR = 16'h8000
   } snt_tap_t;
endpackage

// ---- sim/snt_ctrl_model.sv ----
`timescale 1ns/10ps
// ***********************************************
// Controller model on the far side of the RAM port
// ***********************************************
module snt_ctrl_model (
   // Clock and read path mode
   input  wire logic                           i_clk_sys,
   input  wire logic                           i_pipe,
   // Read data back from the RAM
   input  wire logic [snt_pkg::WORD_W-1:0]     i_dq,
   input  wire logic                           i_dq_oe,
   // Command pins and write data towards the RAM
   output logic      [snt_pkg::ADDR_W-1:0]     o_addr,
   output logic      [snt_pkg::LANES-1:0]      o_lane_wr_n,
   output logic                                o_write_n,
   output logic                                o_sel1_n,
   output logic                                o_sel_hi,
   output logic                                o_sel3_n,
   output logic                                o_burst_step,
   output logic      [snt_pkg::WORD_W-1:0]     o_dq
);
   import snt_pkg::*;
   // Kinds: 0 idle, 1 read, 2 write, 3 read that is not recorded
   logic [1:0]        kind_now, k1, k2, k3;
   logic [WORD_W-1:0] data_now, d1;
   logic [WORD_W:0]   got_q[$];

   // Quiet, deselected bus at time zero
   initial begin
      {o_addr, o_lane_wr_n, o_write_n, o_sel1_n, o_sel_hi, o_sel3_n, o_burst_step} = '1;
      o_sel_hi = 1'b0;
      o_burst_step = 1'b0;
      o_dq = '0;
      {kind_now, k1, k2, k3} = '0;
      {data_now, d1} = '0;
   end

   // One command per clock, launched just after an edge
   task automatic cmd(input logic [1:0] kind, input logic step, input logic [2:0] sel,
                      input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln, input logic [WORD_W-1:0] d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_lane_wr_n <= ln;
      o_write_n <= (kind != 2'h2);
      o_sel1_n <= ~sel[0];
      o_sel_hi <= sel[1];
      o_sel3_n <= ~sel[2];
      o_burst_step <= step;
      kind_now <= kind;
      data_now <= d;
   endtask

   // Late write data slot and read capture slot
   always @(posedge i_clk_sys) begin
      k1 <= kind_now;
      d1 <= data_now;
      k2 <= k1;
      k3 <= k2;
      if (!i_pipe && kind_now == 2'h2) begin
         o_dq <= data_now;
      end else if (i_pipe && k1 == 2'h2) begin
         o_dq <= d1;
      end else begin
         o_dq <= ~o_dq;            // Released bus, never a stale value
      end
      if ((!i_pipe && k2 == 2'h1) || (i_pipe && k3 == 2'h1)) begin
         got_q.push_back({i_dq_oe, i_dq});
      end
   end
endmodule

// ---- sim/sync_no_turnaround_sram_port_bench.sv ----
`timescale 1ns/10ps
// ***********************************************
// Bench for the RAM port
// ***********************************************
module sync_no_turnaround_sram_port_bench;
   import snt_pkg::*;
   logic clk, arst_n, out_en_n, sleep, pipe, lin_n, rdata_oe, asleep, tdo, tdo_oe;
   logic write_n, sel1_n, sel_hi, sel3_n, burst_step, tck, tms, tdi;
   logic [ID_W-1:0]   id_got;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0]  lane_wr_n;
   logic [WORD_W-1:0] wdata, rdata, base, nw, ex;
   logic [WORD_W:0]   exp_q[$];
   int failures, checks_done, m, i, k, n;

   snt_sram_port #(.ADDR_W(ADDR_W)) i_dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_addr(addr),
      .i_lane_wr_n(lane_wr_n), .i_write_n(write_n), .i_chip_sel_lo_1_n(sel1_n), .i_chip_sel_hi(sel_hi),
      .i_chip_sel_lo_3_n(sel3_n), .i_burst_step(burst_step), .i_dq(wdata), .o_dq(rdata), .o_dq_oe(rdata_oe),
      .i_out_en_n(out_en_n), .i_sleep_request(sleep), .i_passthru_read_n(pipe), .i_linear_order_n(lin_n),
      .o_asleep(asleep), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe));
   snt_ctrl_model i_ctrl (.i_clk_sys(clk), .i_pipe(pipe), .i_dq(rdata), .i_dq_oe(rdata_oe), .o_addr(addr),
      .o_lane_wr_n(lane_wr_n), .o_write_n(write_n), .o_sel1_n(sel1_n), .o_sel_hi(sel_hi), .o_sel3_n(sel3_n),
      .o_burst_step(burst_step), .o_dq(wdata));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] want);
      checks_done++;
      if (got !== want) begin
         failures++;
         $display("BAD at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   task automatic complete_run;
      $display("TB: %0d checks, %0d failures", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // One slow scan clock pulse; the port samples the scan pins on the system clock
   task automatic scan_pulse(input logic tms_v);
      tms <= tms_v;
      tdi <= 1'b0;
      repeat (8) @(posedge clk);
      tck <= 1'b1;
      repeat (8) @(posedge clk);
      tck <= 1'b0;
      repeat (8) @(posedge clk);
   endtask

   // One command; a recorded read queues its expected slot
   task automatic go(input logic [1:0] kind, input logic step, input logic [2:0] sel, input logic [ADDR_W-1:0] a,
                     input logic [LANES-1:0] ln, input logic [WORD_W-1:0] d, input logic eo);
      i_ctrl.cmd(kind, step, sel, a, ln, d);
      if (kind == 2'h1) begin
         exp_q.push_back({eo, d});
      end
   endtask

   // Idle until the pipe is empty, then compare every read slot
   task automatic drain(input string name);
      logic [WORD_W:0] g, e;
      repeat (5) go(2'h0, 1'b0, 3'h0, '0, 4'hF, '0, 1'b0);
      check(WORD_W'(i_ctrl.got_q.size()), WORD_W'(exp_q.size()));
      while (exp_q.size() > 0 && i_ctrl.got_q.size() > 0) begin
         e = exp_q.pop_front();
         g = i_ctrl.got_q.pop_front();
         check(WORD_W'(g[WORD_W]), WORD_W'(e[WORD_W]));
         if (e[WORD_W]) begin
            check(g[WORD_W-1:0], e[WORD_W-1:0]);
         end
      end
      exp_q.delete();
      i_ctrl.got_q.delete();
      $display("TB: test %s done at %0t", name, $time);
   endtask

   // Hang guard, well beyond the thousand or so cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      complete_run();
   end

   // Main sequence
   initial begin
      {failures, checks_done} = '0;
      {arst_n, out_en_n, sleep, pipe, lin_n, tck, tdi} = '0;
      tms = 1'b1;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (m = 0; m < 2; m++) begin
         pipe <= m[0];
         repeat (4) go(2'h0, 1'b0, 3'h0, '0, 4'hF, '0, 1'b0);
         // Direction changes on each of the first three edges, then two reads; no dead cycles
         go(2'h2, 1'b0, 3'h7, 10'h010, 4'h0, 36'h1_2345_6789, 1'b0);
         go(2'h1, 1'b0, 3'h7, 10'h010, 4'h0, 36'h1_2345_6789, 1'b1);
         go(2'h2, 1'b0, 3'h7, 10'h011, 4'h0, 36'hE_DCBA_9876, 1'b0);
         go(2'h1, 1'b0, 3'h7, 10'h011, 4'h0, 36'hE_DCBA_9876, 1'b1);
         go(2'h1, 1'b0, 3'h7, 10'h010, 4'h0, 36'h1_2345_6789, 1'b1);
         drain("turnaround");
         // Each lane alone over a known word
         base = 36'h1_2345_6789;
         nw = 36'hE_DCBA_9876;
         for (i = 0; i < LANES; i++) begin
            ex = base;
            ex[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
            go(2'h2, 1'b0, 3'h7, 10'h020, 4'h0, base, 1'b0);
            go(2'h2, 1'b0, 3'h7, 10'h020, ~(4'h1 << i), nw, 1'b0);
            go(2'h1, 1'b0, 3'h7, 10'h020, 4'hF, ex, 1'b1);
         end
         drain("lanes");
         // Bursts in both orders; step ignores the address pins
         for (n = 0; n < 2; n++) begin
            lin_n <= n[0];
            repeat (3) go(2'h0, 1'b0, 3'h0, '0, 4'hF, '0, 1'b0);
            for (k = 0; k < 4; k++) begin
               go(2'h2, 1'b0, 3'h7, 10'h030 + k, 4'h0, 36'h0_0000_0100 + k, 1'b0);
            end
            for (k = 0; k < 4; k++) begin
               i = n ? (1 ^ k) : ((1 + k) & 3);
               go(2'h1, k != 0, 3'h7, k ? 10'h3FF : 10'h031, 4'hF, 36'h0_0000_0100 + i, 1'b1);
            end
            for (k = 0; k < 4; k++) begin
               go(2'h2, k != 0, 3'h7, k ? 10'h3FF : 10'h032, 4'h0, 36'h0_0000_0200 + k, 1'b0);
            end
            for (k = 0; k < 4; k++) begin
               i = n ? (2 ^ k) : ((2 + k) & 3);
               go(2'h1, 1'b0, 3'h7, 10'h030 + i, 4'hF, 36'h0_0000_0200 + k, 1'b1);
            end
            drain("burst");
         end
      end
      // Any one select inactive blocks the write and the read
      go(2'h2, 1'b0, 3'h7, 10'h040, 4'h0, 36'h0_5A5A_5A5A, 1'b0);
      for (i = 0; i < 3; i++) begin
         go(2'h2, 1'b0, 3'h7 & ~(3'h1 << i), 10'h040, 4'h0, 36'hF_FFFF_FFFF, 1'b0);
         go(2'h1, 1'b0, 3'h7 & ~(3'h1 << i), 10'h040, 4'hF, '0, 1'b0);
      end
      go(2'h1, 1'b0, 3'h7, 10'h040, 4'hF, 36'h0_5A5A_5A5A, 1'b1);
      drain("selects");
      // Output enable cuts the drivers mid-burst, off the clock edge
      for (k = 0; k < 4; k++) begin
         go(2'h3, k != 0, 3'h7, 10'h030, 4'hF, '0, 1'b0);
      end
      #2;
      check(WORD_W'(rdata_oe), WORD_W'(1'b1));
      out_en_n = 1'b1;
      #1;
      check(WORD_W'(rdata_oe), WORD_W'(1'b0));
      go(2'h1, 1'b0, 3'h7, 10'h040, 4'hF, '0, 1'b0);
      drain("output enable");
      out_en_n <= 1'b0;
      // Sleep is taken at once and swallows commands
      #3;
      sleep = 1'b1;
      #1;
      check(WORD_W'(asleep), WORD_W'(1'b1));
      go(2'h1, 1'b0, 3'h7, 10'h040, 4'hF, '0, 1'b0);
      drain("sleep");
      sleep <= 1'b0;
      repeat (3) go(2'h0, 1'b0, 3'h0, '0, 4'hF, '0, 1'b0);
      check(WORD_W'(asleep), WORD_W'(1'b0));
      go(2'h1, 1'b0, 3'h7, 10'h040, 4'hF, 36'h0_5A5A_5A5A, 1'b1);
      drain("wake");
      check(WORD_W'(tdo_oe), WORD_W'(1'b0));
      // Scan: walk to shift-DR and read the identity word out, low bit first
      scan_pulse(1'b0);
      scan_pulse(1'b1);
      scan_pulse(1'b0);
      for (k = 0; k < ID_W; k++) begin
         scan_pulse(1'b0);
         id_got[k] = tdo;
      end
      check(WORD_W'(tdo_oe), WORD_W'(1'b1));
      check(WORD_W'(id_got), WORD_W'(ID_VALUE));
      $display("TB: test scan done at %0t", $time);
      complete_run();
   end
endmodule

// ---- src/snt_sram_port.sv ----
`timescale 1ns/10ps
module snt_sram_port #(
   parameter int unsigned ADDR_W = snt_pkg::ADDR_W
) (
   // Clock and reset
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_arst_n,
   // Synchronous command pins
   input  wire logic [ADDR_W-1:0]           i_addr,
   input  wire logic [snt_pkg::LANES-1:0]   i_lane_wr_n,
   input  wire logic                        i_write_n,
   input  wire logic                        i_chip_sel_lo_1_n,
   input  wire logic                        i_chip_sel_hi,
   input  wire logic                        i_chip_sel_lo_3_n,
   input  wire logic                        i_burst_step,
   // Data pins
   input  wire logic [snt_pkg::WORD_W-1:0]  i_dq,
   output logic      [snt_pkg::WORD_W-1:0]  o_dq,
   output logic                             o_dq_oe,
   // Asynchronous and static pins
   input  wire logic                        i_out_en_n,
   input  wire logic                        i_sleep_request,
   input  wire logic                        i_passthru_read_n,
   input  wire logic                        i_linear_order_n,
   output logic                             o_asleep,
   // Scan port
   input  wire logic                        i_tck,
   input  wire logic                        i_tms,
   input  wire logic                        i_tdi,
   output logic                             o_tdo,
   output logic                             o_tdo_oe
);
   import snt_pkg::*;

   // ***********************************************
   // Helpers
   // ***********************************************
   // Lane merge, enables active low
   function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old_w,
                                              input logic [WORD_W-1:0] new_w,
                                              input logic [LANES-1:0]  en_n);
      logic [WORD_W-1:0] r;
      r = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (!en_n[i]) begin
            r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
         end
      end
      return r;
   endfunction

   // Burst low bits for a beat
   function automatic logic [BURST_W-1:0] beat_lo(input logic [BURST_W-1:0] start,
                                                 input logic [BURST_W-1:0] beat,
                                                 input logic              lin);
      return lin ? BURST_W'(start + beat) : (start ^ beat);
   endfunction

   // ***********************************************
   // Static pin synchronisers
   // ***********************************************
   logic [1:0] mode_sync_reg;
   logic [1:0] order_sync_reg;
   // Static pins still cross in; they change only while the bus is idle, so latency does not matter
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_sync_reg  <= 2'h0;
         order_sync_reg <= 2'h0;
      end else begin
         mode_sync_reg  <= {mode_sync_reg[0], i_passthru_read_n};
         order_sync_reg <= {order_sync_reg[0], i_linear_order_n};
      end
   end
   wire logic pipe_mode = mode_sync_reg[1];  // see [RULE17] [RULE8]
   wire logic lin_order = ~order_sync_reg[1]; // see [RULE11] [RULE2]

   // ***********************************************
   // Sleep
   // ***********************************************
   // Set at once by the pin, released at the next edge after it drops
   always_ff @(posedge i_clk_sys or negedge i_arst_n or posedge i_sleep_request) begin
      if (!i_arst_n) begin
         o_asleep <= 1'b0;
      end else if (i_sleep_request) begin
         o_asleep <= 1'b1; // see [RULE3] [RULE12]
      end else begin
         o_asleep <= 1'b0;
      end
   end

   // ***********************************************
   // Command decode and burst counter
   // ***********************************************
   logic [ADDR_W-1:0]  base_reg;
   logic [BURST_W-1:0] beat_reg;
   logic               burst_act_reg;
   logic               burst_wr_reg;
   wire logic selected  = ~i_chip_sel_lo_1_n & i_chip_sel_hi & ~i_chip_sel_lo_3_n; // see [RULE10] [RULE14]
   wire logic cmd_new   = ~o_asleep & ~i_burst_step & selected;
   wire logic cmd_step  = ~o_asleep & i_burst_step & burst_act_reg;  // see [RULE16]
   wire logic accept    = cmd_new | cmd_step;                        // see [RULE1] [RULE7]
   wire logic [BURST_W-1:0] beat_next = BURST_W'(beat_reg + 1'b1);
   wire logic [ADDR_W-1:0]  step_addr = {base_reg[ADDR_W-1:BURST_W],
                                         beat_lo(base_reg[BURST_W-1:0], beat_next, lin_order)}; // see [RULE18]
   wire logic [ADDR_W-1:0]  cmd_addr  = cmd_step ? step_addr : i_addr;
   wire logic               cmd_wr    = cmd_step ? burst_wr_reg : ~i_write_n;

   // Burst state follows each new command or step
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         base_reg      <= '0;
         beat_reg      <= '0;
         burst_act_reg <= 1'b0;
         burst_wr_reg  <= 1'b0;
      end else if (cmd_new) begin
         base_reg      <= i_addr;
         beat_reg      <= '0;
         burst_act_reg <= 1'b1;
         burst_wr_reg  <= ~i_write_n;
      end else if (cmd_step) begin
         beat_reg      <= beat_next; // see [RULE16]
      end else if (!i_burst_step) begin
         burst_act_reg <= 1'b0;
      end
   end

   // ***********************************************
   // Access pipeline
   // ***********************************************
   logic [WORD_W-1:0] mem [2**ADDR_W];
   logic              s1_vld_reg, s1_wr_reg, s2_vld_reg, s2_wr_reg;
   logic [ADDR_W-1:0] s1_addr_reg, s2_addr_reg;
   logic [LANES-1:0]  s1_be_reg, s2_be_reg;
   logic [WORD_W-1:0] rd2_reg;

   // Late write: data slot matches the read slot of the same mode
   wire logic              wr_fire = pipe_mode ? (s2_vld_reg & s2_wr_reg) : (s1_vld_reg & s1_wr_reg); // see [RULE19]
   wire logic [ADDR_W-1:0] wr_addr = pipe_mode ? s2_addr_reg : s1_addr_reg;
   wire logic [LANES-1:0]  wr_be   = pipe_mode ? s2_be_reg : s1_be_reg;
   // Forward a write landing on the same edge so back-to-back reads see it
   wire logic [WORD_W-1:0] mem_rd  = (wr_fire && wr_addr == s1_addr_reg) ?
                                     merge(mem[s1_addr_reg], i_dq, wr_be) : mem[s1_addr_reg];
   wire logic [WORD_W-1:0] dq_next = pipe_mode ? rd2_reg : mem_rd; // see [RULE6] [RULE8]
   wire logic              oe_next = ~o_asleep & (pipe_mode ? (s2_vld_reg & ~s2_wr_reg) : (s1_vld_reg & ~s1_wr_reg));

   // Command and data stages
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_vld_reg  <= 1'b0;
         s1_wr_reg   <= 1'b0;
         s1_addr_reg <= '0;
         s1_be_reg   <= '1;
         s2_vld_reg  <= 1'b0;
         s2_wr_reg   <= 1'b0;
         s2_addr_reg <= '0;
         s2_be_reg   <= '1;
         rd2_reg     <= '0;
         o_dq        <= '0;
      end else begin
         s1_vld_reg  <= accept;  // see [RULE1]
         s1_wr_reg   <= cmd_wr;
         s1_addr_reg <= cmd_addr;
         s1_be_reg   <= i_lane_wr_n;
         s2_vld_reg  <= s1_vld_reg;
         s2_wr_reg   <= s1_wr_reg;
         s2_addr_reg <= s1_addr_reg;
         s2_be_reg   <= s1_be_reg;
         rd2_reg     <= mem_rd;  // see [RULE6]
         o_dq        <= dq_next;
      end
   end

   // Array write, no reset on the storage itself
   always_ff @(posedge i_clk_sys) begin
      if (wr_fire) begin
         mem[wr_addr] <= merge(mem[wr_addr], i_dq, wr_be); // see [RULE5] [RULE9] [RULE15]
      end
   end

   // Driver enable, killed at once by the output enable pin
   always_ff @(posedge i_clk_sys or negedge i_arst_n or posedge i_out_en_n) begin
      if (!i_arst_n) begin
         o_dq_oe <= 1'b0;
      end else if (i_out_en_n) begin
         o_dq_oe <= 1'b0; // see [RULE3] [RULE4]
      end else begin
         o_dq_oe <= oe_next;
      end
   end

   // ***********************************************
   // Boundary-scan port
   // ***********************************************
   logic [2:0]        tck_s_reg, tms_s_reg, tdi_s_reg;
   snt_tap_t          tap_reg, tap_next;
   logic [IR_W-1:0]   ir_reg, ir_sh_reg;
   logic [ID_W-1:0]   dr_sh_reg;
   // Scan runs far below the system clock, so sampling it is safe
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tck_s_reg <= 3'h0;
         tms_s_reg <= 3'h7;
         tdi_s_reg <= 3'h0;
      end else begin
         tck_s_reg <= {tck_s_reg[1:0], i_tck};
         tms_s_reg <= {tms_s_reg[1:0], i_tms};
         tdi_s_reg <= {tdi_s_reg[1:0], i_tdi};
      end
   end
   wire logic tck_rise = tck_s_reg[1] & ~tck_s_reg[2];
   wire logic tck_fall = ~tck_s_reg[1] & tck_s_reg[2];
   wire logic tms      = tms_s_reg[2];
   wire logic tdi      = tdi_s_reg[2];

   // TAP controller next state
   always_comb begin
      case (tap_reg)
         TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = tms ? TAP_UP_DR  : TAP_PA_DR;
         TAP_PA_DR:  tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: tap_next = tms ? TAP_UP_DR  : TAP_SH_DR;
         TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = tms ? TAP_UP_IR  : TAP_PA_IR;
         TAP_PA_IR:  tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: tap_next = tms ? TAP_UP_IR  : TAP_SH_IR;
         default:    tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   wire logic is_byp = (ir_reg != IR_IDCODE);
   // TAP state and shift registers on the scan clock rising edge
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tap_reg   <= TAP_RESET;
         ir_reg    <= IR_IDCODE;
         ir_sh_reg <= '0;
         dr_sh_reg <= '0;
      end else if (tck_rise) begin
         tap_reg <= tap_next; // see [RULE13]
         case (tap_reg)
            TAP_RESET:  ir_reg    <= IR_IDCODE;
            TAP_CAP_IR: ir_sh_reg <= IR_CAPT;
            TAP_SH_IR:  ir_sh_reg <= {tdi, ir_sh_reg[IR_W-1:1]};
            TAP_UP_IR:  ir_reg    <= ir_sh_reg;
            TAP_CAP_DR: dr_sh_reg <= is_byp ? '0 : ID_VALUE;
            TAP_SH_DR:  dr_sh_reg <= is_byp ? {{(ID_W-1){1'b0}}, tdi} : {tdi, dr_sh_reg[ID_W-1:1]};
            default:    ir_reg    <= ir_reg;
         endcase
      end
   end

   // Test data out changes on the falling scan edge
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         o_tdo    <= (tap_reg == TAP_SH_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
         o_tdo_oe <= (tap_reg == TAP_SH_IR) || (tap_reg == TAP_SH_DR);
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   AST_OE_OFF: assert property (i_out_en_n |-> !o_dq_oe) else $error("driver on while output enable off"); // see [RULE4]
   AST_FT_READ: assert property (accept && !cmd_wr && !pipe_mode && !o_asleep ##1 !i_out_en_n && !o_asleep
      |=> i_out_en_n || o_dq_oe) else $error("flow-through read slot missing"); // see [RULE8]
   AST_PIPE_READ: assert property (accept && !cmd_wr && pipe_mode && $stable(pipe_mode) ##1 !o_asleep ##1
      !i_out_en_n && !o_asleep |=> i_out_en_n || (o_dq_oe && o_dq == $past(rd2_reg)))
      else $error("pipelined read slot wrong"); // see [RULE6]
   AST_PIPE_WR: assert property (accept && cmd_wr && pipe_mode ##1 pipe_mode |=> wr_fire)
      else $error("pipelined write slot wrong"); // see [RULE19]
   AST_FT_WR: assert property (accept && cmd_wr && !pipe_mode |=> wr_fire && wr_addr == $past(cmd_addr))
      else $error("flow-through write slot wrong"); // see [RULE5]
   AST_SELECT: assert property (!i_burst_step && !(!i_chip_sel_lo_1_n && i_chip_sel_hi && !i_chip_sel_lo_3_n)
      |=> !s1_vld_reg) else $error("access taken while deselected"); // see [RULE10]
   AST_SLEEP: assert property (i_sleep_request |-> o_asleep && !accept) else $error("command taken in sleep"); // see [RULE12]
   AST_BURST: assert property (cmd_new ##1 cmd_step |-> s1_addr_reg[BURST_W-1:0] == $past(i_addr[BURST_W-1:0])
      && cmd_addr[BURST_W-1:0] == (lin_order ? BURST_W'(s1_addr_reg[BURST_W-1:0] + 1'b1)
      : (s1_addr_reg[BURST_W-1:0] ^ 2'h1))) else $error("burst address step wrong"); // see [RULE18]
   AST_BURST_HI: assert property (cmd_step |-> cmd_addr[ADDR_W-1:BURST_W] == base_reg[ADDR_W-1:BURST_W])
      else $error("burst left its block"); // see [RULE16]
   COV_RWR: cover property (accept && !cmd_wr ##1 accept && cmd_wr ##1 accept && !cmd_wr);
   COV_BURST: cover property (cmd_new ##1 cmd_step [*3]);
   COV_SLEEP: cover property (o_asleep ##1 !o_asleep ##1 accept);
endmodule
